// file: core/tsrp_target.sv
// Two-wire target port giving access to 16-bit internal registers.
// Operation
// [R1] Target only; never drives clock or conditions.
// [R2] Address is fixed 01011 plus two straps.
// [R3] Strap high is bit 1, low bit 0.
// [R4] Data fall with clock high starts.
// [R5] Shift eight bits: address then direction.
// [R6] Acknowledge own address; otherwise stay idle.
// [R7] Direction zero writes, one reads.
// [R8] Bytes are eight bits plus acknowledge.
// [R9] Change data only while clock low.
// [R10] Stop returns idle and clears pointer.
// [R11] Two bytes load ten-bit register pointer.
// [R12] Data byte pairs form big-endian word.
// [R13] Pointer advances after each stored word.
// [R14] No wrap; writes at maximum dropped.
// [R15] Master sends even data byte count.
// [R16] Repeated start begins new address phase.
// [R17] Master sets pointer before reading.
// [R18] Read returns upper byte then lower.
// [R19] Advance after read until not-acknowledge.
// [R20] At maximum, keep returning last register.
// [R21] Release acknowledge slot; not-acknowledge stops driving.
`timescale 1ns/10ps
`default_nettype none
module tsrp_target
    import tsrp_pkg::*;
#(
    parameter int PTR_W = TSRP_PTR_W
)
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Address straps.
    input wire logic addr_strap_high_i,
    input wire logic addr_strap_low_i,
    // Register file side.
    output logic [PTR_W-1:0] reg_addr_o,
    output logic [TSRP_DATA_W-1:0] reg_wdata_o,
    output logic reg_we_o,
    input wire logic [TSRP_DATA_W-1:0] reg_rdata_i,
    // Bus.
    tsrp_bus_if.target bus
);
    typedef enum logic [2:0] {
        TSRP_ST_IDLE = 3'b000,
        TSRP_ST_ADDR = 3'b001,
        TSRP_ST_WR = 3'b010,
        TSRP_ST_RD = 3'b011
    } tsrp_state_t;

    logic [2:0] scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;
    logic scl_q_r, scl_q_nxt, sda_q_r, sda_q_nxt;
    tsrp_state_t st_r, st_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [1:0] wbyte_r, wbyte_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic [PTR_W-1:0] ptr_r, ptr_nxt;
    logic rdlo_r, rdlo_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic ack_r, ack_nxt;
    logic drv_r, drv_nxt;
    logic sda_out_r, sda_out_nxt;
    logic [TSRP_DATA_W-1:0] wdata_r, wdata_nxt;
    logic we_r, we_nxt;
    logic scl_f, sda_f, scl_rise, scl_fall, start_c, stop_c;
    logic [6:0] own_addr;
    logic rd_lo;

    // A stale half-word flag from an earlier transfer must not pick the first read byte.
    assign rd_lo = rdlo_r && (st_r == TSRP_ST_RD);

    assign own_addr = {TSRP_ADDR_FIXED, addr_strap_high_i, addr_strap_low_i}; // [R2] [R3]

    // Pins settle once the second and third stages agree.
    always_comb
    begin
        scl_s_nxt = {scl_s_r[1:0], bus.scl};
        sda_s_nxt = {sda_s_r[1:0], bus.sda};
        scl_q_nxt = (scl_s_r[2] == scl_s_r[1]) ? scl_s_r[2] : scl_q_r;
        sda_q_nxt = (sda_s_r[2] == sda_s_r[1]) ? sda_s_r[2] : sda_q_r;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_s_r <= TSRP_SYNC_RST;
            sda_s_r <= TSRP_SYNC_RST;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_s_r <= scl_s_nxt;
            sda_s_r <= sda_s_nxt;
            scl_q_r <= scl_q_nxt;
            sda_q_r <= sda_q_nxt;
        end
    end

    assign scl_f = scl_q_nxt;
    assign sda_f = sda_q_nxt;
    assign scl_rise = scl_f && !scl_q_r;
    assign scl_fall = !scl_f && scl_q_r;
    assign start_c = scl_f && scl_q_r && sda_q_r && !sda_f; // [R4]
    assign stop_c = scl_f && scl_q_r && !sda_q_r && sda_f; // [R10]

    always_comb
    begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        wbyte_nxt = wbyte_r;
        hi_nxt = hi_r;
        ptr_nxt = ptr_r;
        rdlo_nxt = rdlo_r;
        tx_nxt = tx_r;
        ack_nxt = ack_r;
        drv_nxt = drv_r;
        sda_out_nxt = sda_out_r;
        wdata_nxt = wdata_r;
        we_nxt = 1'b0;
        if (stop_c)
        begin
            st_nxt = TSRP_ST_IDLE; // [R10]
            ptr_nxt = TSRP_PTR_RST[PTR_W-1:0];
            drv_nxt = 1'b0;
        end
        else if (start_c)
        begin
            st_nxt = TSRP_ST_ADDR; // [R4] [R16]
            // The clock fall that closes a start is no data bit, so count from one below zero.
            bit_nxt = 4'hF;
            drv_nxt = 1'b0;
            ack_nxt = 1'b0;
        end
        else if (st_r != TSRP_ST_IDLE && scl_rise)
        begin
            if (bit_r < TSRP_ACK_SLOT)
            begin
                sh_nxt = {sh_r[6:0], sda_f}; // [R5] [R8]
            end
            else if (st_r == TSRP_ST_RD && sda_f)
            begin
                st_nxt = TSRP_ST_IDLE; // [R21]
            end
        end
        else if (st_r != TSRP_ST_IDLE && scl_fall)
        begin
            // All drive changes happen just after a falling clock edge. [R9]
            if (bit_r == TSRP_ACK_SLOT)
            begin
                bit_nxt = 4'h0;
                drv_nxt = 1'b0;
                if (st_r == TSRP_ST_ADDR && ack_r)
                begin
                    st_nxt = sh_r[0] ? TSRP_ST_RD : TSRP_ST_WR; // [R7]
                    wbyte_nxt = 2'h0;
                    rdlo_nxt = 1'b0;
                end
                else if (st_r == TSRP_ST_ADDR)
                begin
                    st_nxt = TSRP_ST_IDLE; // [R6]
                end
                if (st_r == TSRP_ST_RD || (st_r == TSRP_ST_ADDR && ack_r && sh_r[0]))
                begin
                    // Read byte loads here; the acknowledge slot is released. [R21]
                    tx_nxt = rd_lo ? reg_rdata_i[7:0] : reg_rdata_i[15:8]; // [R18]
                    if (rd_lo && ptr_r != TSRP_PTR_MAX[PTR_W-1:0])
                    begin
                        ptr_nxt = ptr_r + 1'b1; // [R19] [R20]
                    end
                    rdlo_nxt = !rd_lo;
                    drv_nxt = 1'b1;
                    sda_out_nxt = rd_lo ? reg_rdata_i[7] : reg_rdata_i[15];
                end
            end
            else
            begin
                bit_nxt = bit_r + 1'b1;
                if (st_r == TSRP_ST_RD && bit_r < 4'h7)
                begin
                    sda_out_nxt = tx_r[6 - bit_r[2:0]];
                end
                else if (bit_r == 4'h7)
                begin
                    drv_nxt = 1'b0;
                    sda_out_nxt = 1'b0;
                    if (st_r == TSRP_ST_ADDR)
                    begin
                        ack_nxt = (sh_r[7:1] == own_addr); // [R6]
                        drv_nxt = (sh_r[7:1] == own_addr);
                    end
                    else if (st_r == TSRP_ST_WR)
                    begin
                        drv_nxt = 1'b1; // [R8]
                        unique case (wbyte_r)
                            2'h0: ptr_nxt[PTR_W-1:8] = sh_r[PTR_W-9:0]; // [R11]
                            2'h1: ptr_nxt[7:0] = sh_r; // [R11]
                            2'h2: hi_nxt = sh_r; // [R12]
                            2'h3:
                            begin
                                wdata_nxt = {hi_r, sh_r}; // [R12]
                                we_nxt = (ptr_r != TSRP_PTR_MAX[PTR_W-1:0]); // [R14]
                                if (ptr_r != TSRP_PTR_MAX[PTR_W-1:0])
                                begin
                                    ptr_nxt = ptr_r + 1'b1; // [R13]
                                end
                            end
                        endcase
                        wbyte_nxt = (wbyte_r == 2'h3) ? 2'h2 : wbyte_r + 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= TSRP_ST_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            wbyte_r <= 2'h0;
            hi_r <= 8'h00;
            ptr_r <= TSRP_PTR_RST[PTR_W-1:0];
            rdlo_r <= 1'b0;
            tx_r <= 8'h00;
            ack_r <= 1'b0;
            drv_r <= 1'b0;
            sda_out_r <= 1'b0;
            wdata_r <= 16'h0000;
            we_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            wbyte_r <= wbyte_nxt;
            hi_r <= hi_nxt;
            ptr_r <= ptr_nxt;
            rdlo_r <= rdlo_nxt;
            tx_r <= tx_nxt;
            ack_r <= ack_nxt;
            drv_r <= drv_nxt;
            sda_out_r <= sda_out_nxt;
            wdata_r <= wdata_nxt;
            we_r <= we_nxt;
        end
    end

    assign reg_addr_o = ptr_r;
    assign reg_wdata_o = wdata_r;
    assign reg_we_o = we_r;
    // Only the data line is ever driven, and only low for a zero. [R1]
    assign bus.sda_s_o = sda_out_r;
    assign bus.sda_s_oe = drv_r && !sda_out_r;
endmodule
`default_nettype wire

// file: core/tsrp_pkg.sv
// Shared constants for the two-wire register port and its master.
package tsrp_pkg;
    localparam int TSRP_PTR_W = 10;
    localparam int TSRP_DATA_W = 16;
    localparam logic [4:0] TSRP_ADDR_FIXED = 5'h0B;
    localparam logic [9:0] TSRP_PTR_RST = 10'h000;
    localparam logic [9:0] TSRP_PTR_MAX = 10'h3FF;
    localparam logic [3:0] TSRP_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TSRP_ACK_SLOT = 4'h8;
    localparam int TSRP_LINK_PERIOD_NS = 1000;
    localparam int TSRP_CLK_PERIOD_NS = 10;
    localparam int TSRP_HALF_CYC = TSRP_LINK_PERIOD_NS / (2 * TSRP_CLK_PERIOD_NS);
    localparam logic [2:0] TSRP_SYNC_RST = 3'h7;
endpackage

// file: core/tsrp_bus_if.sv
// Two-wire bus carrier joining the register port and its master.
`timescale 1ns/10ps
`default_nettype none
interface tsrp_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire scl;
    wire sda;
    // Open-drain wire: any enabled driver that drives low pulls the line low.
    assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
    assign sda = ((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o)) ? 1'b0 : 1'b1;
    modport target (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe,
                    output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// file: core/tsrp_master.sv
// Two-wire bus master issuing register writes and reads.
`timescale 1ns/10ps
`default_nettype none
module tsrp_master
    import tsrp_pkg::*;
#(
    parameter int HALF_CYC = TSRP_HALF_CYC
)
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Command side: one byte per request.
    input wire logic cmd_valid_i,
    input wire logic cmd_start_i,
    input wire logic cmd_stop_i,
    input wire logic cmd_read_i,
    input wire logic cmd_nack_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_ack_o,
    output logic rsp_valid_o,
    // Bus.
    tsrp_bus_if.master bus
);
    typedef enum logic [2:0] {
        TSRP_M_IDLE = 3'b000,
        TSRP_M_START = 3'b001,
        TSRP_M_BIT = 3'b010,
        TSRP_M_STOP = 3'b011,
        TSRP_M_DONE = 3'b100
    } tsrp_mstate_t;

    tsrp_mstate_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [8:0] sh_r, sh_nxt;
    logic rd_r, rd_nxt, stop_r, stop_nxt;
    logic scl_r, scl_nxt, sda_r, sda_nxt;
    logic rv_r, rv_nxt;
    logic tick;

    // The master makes the link clock by dividing its own clock. [R4]
    assign tick = (cnt_r == 16'(HALF_CYC - 1));

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = tick ? 16'h0000 : cnt_r + 16'h0001;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        stop_nxt = stop_r;
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        rv_nxt = 1'b0;
        unique case (st_r)
            TSRP_M_IDLE, TSRP_M_DONE:
            begin
                cnt_nxt = 16'h0000;
                if (cmd_valid_i)
                begin
                    sh_nxt = cmd_read_i ? {8'hFF, cmd_nack_i} : {cmd_data_i, 1'b1};
                    rd_nxt = cmd_read_i;
                    stop_nxt = cmd_stop_i;
                    bit_nxt = 4'h0;
                    ph_nxt = 2'h0;
                    st_nxt = cmd_start_i ? TSRP_M_START : TSRP_M_BIT;
                end
            end
            TSRP_M_START:
            begin
                if (tick)
                begin
                    ph_nxt = ph_r + 2'h1;
                    // Release both lines, then pull data low under a high clock. [R4] [R16]
                    unique case (ph_r)
                        2'h0: sda_nxt = 1'b1;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sda_nxt = 1'b0;
                        2'h3:
                        begin
                            scl_nxt = 1'b0;
                            st_nxt = TSRP_M_BIT;
                        end
                    endcase
                end
            end
            TSRP_M_BIT:
            begin
                if (tick)
                begin
                    ph_nxt = ph_r + 2'h1;
                    unique case (ph_r)
                        2'h0: sda_nxt = sh_r[8]; // [R9]
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sh_nxt = {sh_r[7:0], bus.sda};
                        2'h3:
                        begin
                            scl_nxt = 1'b0;
                            bit_nxt = bit_r + 4'h1;
                            if (bit_r == TSRP_ACK_SLOT) // [R8]
                            begin
                                rv_nxt = 1'b1;
                                st_nxt = stop_r ? TSRP_M_STOP : TSRP_M_DONE;
                                ph_nxt = 2'h0;
                            end
                        end
                    endcase
                end
            end
            TSRP_M_STOP:
            begin
                if (tick)
                begin
                    ph_nxt = ph_r + 2'h1;
                    unique case (ph_r)
                        2'h0: sda_nxt = 1'b0;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: sda_nxt = 1'b1; // [R10]
                        2'h3: st_nxt = TSRP_M_DONE;
                    endcase
                end
            end
            default: st_nxt = TSRP_M_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= TSRP_M_IDLE;
            cnt_r <= 16'h0000;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 9'h1FF;
            rd_r <= 1'b0;
            stop_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            rv_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            stop_r <= stop_nxt;
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
            rv_r <= rv_nxt;
        end
    end

    // Reads shift in data bits; the response holds the byte and the acknowledge bit.
    assign rsp_data_o = sh_r[8:1];
    assign rsp_ack_o = !sh_r[0];
    assign rsp_valid_o = rv_r;
    assign cmd_ready_o = (st_r == TSRP_M_IDLE) || (st_r == TSRP_M_DONE);
    assign bus.scl_o = scl_r;
    assign bus.scl_oe = !scl_r;
    assign bus.sda_m_o = sda_r;
    assign bus.sda_m_oe = !sda_r;
endmodule
`default_nettype wire

// file: verification/tsrp_props.sv
// Concurrent checks on the two-wire bus between the register port and its master.
`timescale 1ns/10ps
`default_nettype none
module tsrp_props
    import tsrp_pkg::*;
(
    // Clock, reset and straps.
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic addr_strap_high_i,
    input wire logic addr_strap_low_i,
    // Bus signals.
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_o,
    input wire logic sda_s_oe
);
    logic scl_r, sda_r, first_r, sel_r, rd_r, nack_r;
    logic [3:0] nbit_r;
    logic [7:0] sh_r;
    wire logic pull = sda_s_oe && !sda_s_o;
    wire logic rise = scl && !scl_r;
    wire logic fall = !scl && scl_r;
    wire logic cond = scl && scl_r && (sda != sda_r);
    wire logic match = sh_r[7:1] == {TSRP_ADDR_FIXED, addr_strap_high_i, addr_strap_low_i};
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // The bus is tracked from the wires alone, so a target fault cannot hide in shared state.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {scl_r, sda_r} <= 2'h3;
            {first_r, sel_r, rd_r, nack_r} <= 4'h0;
            nbit_r <= 4'h0;
            sh_r <= 8'h00;
        end
        else
        begin
            {scl_r, sda_r} <= {scl, sda};
            if (cond)
            begin
                nbit_r <= 4'h0;
                first_r <= !sda;
                {sel_r, nack_r} <= 2'h0;
            end
            else if (rise && nbit_r == 4'h8)
            begin
                nbit_r <= 4'h0;
                first_r <= 1'b0;
                if (first_r)
                    {sel_r, rd_r} <= {match, sh_r[0]};
                else if (rd_r && sda)
                    nack_r <= 1'b1;
            end
            else if (rise)
            begin
                nbit_r <= nbit_r + 4'h1;
                sh_r <= {sh_r[6:0], sda};
            end
        end
    end
    sequence s_slot;
        rise && nbit_r == 4'h8;
    endsequence
    sequence s_addr_done;
        fall && first_r && nbit_r == 4'h8 && match;
    endsequence
    a_addr_ack: assert property (s_slot ##0 first_r |-> sda == !match)
        else $error("address acknowledge does not follow the match");
    a_ack_drive: assert property (s_addr_done |-> ##[1:7] pull)
        else $error("target late to pull the acknowledge");
    a_write_ack: assert property (s_slot ##0 (!first_r && sel_r && !rd_r) |-> !sda)
        else $error("written byte not acknowledged");
    a_read_release: assert property (s_slot ##0 (!first_r && sel_r && rd_r) |-> !pull)
        else $error("target holds the line in a read acknowledge slot");
    a_nack_silent: assert property (nack_r |-> !pull)
        else $error("target drives after not-acknowledge");
    a_pull_window: assert property (pull |-> (first_r ? nbit_r == 4'h8 : sel_r))
        else $error("target drives while not selected");
    a_stable_high: assert property ($changed(pull) |-> !scl)
        else $error("target changes data while clock high");
    a_no_target_cond: assert property (cond |-> !pull && !$past(pull))
        else $error("target takes part in a start or stop");
endmodule
`default_nettype wire

// file: verification/i2c_slave_register_port_tb_top.sv
// Self-checking bench joining the register port to the bus master.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_register_port_tb_top
    import tsrp_pkg::*;
;
    logic core_clk_i, rst_i, strap_h, strap_l, cmd_valid, cmd_start, cmd_stop, cmd_read;
    logic cmd_nack, cmd_ready, rsp_valid, rsp_ack, we;
    logic [7:0] cmd_data, rsp_data;
    logic [9:0] raddr, prev_addr;
    logic [15:0] wdata;
    logic [15:0] mem [0:1023];
    logic [15:0] shadow [0:1023];
    int err_count, n_checks;
    tsrp_bus_if bus_if ();
    tsrp_target i_tsrp_target (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .addr_strap_high_i(strap_h), .addr_strap_low_i(strap_l), .reg_addr_o(raddr),
        .reg_wdata_o(wdata), .reg_we_o(we), .reg_rdata_i(mem[raddr]), .bus(bus_if));
    tsrp_master #(.HALF_CYC(4)) i_tsrp_master (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .cmd_valid_i(cmd_valid), .cmd_start_i(cmd_start), .cmd_stop_i(cmd_stop),
        .cmd_read_i(cmd_read), .cmd_nack_i(cmd_nack), .cmd_data_i(cmd_data),
        .cmd_ready_o(cmd_ready), .rsp_data_o(rsp_data), .rsp_ack_o(rsp_ack),
        .rsp_valid_o(rsp_valid), .bus(bus_if));
    tsrp_props u_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_strap_high_i(strap_h),
        .addr_strap_low_i(strap_l), .scl(bus_if.scl), .sda(bus_if.sda),
        .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe));
    // The pointer advances on the same edge as the strobe, so the write lands one address back.
    always @(posedge core_clk_i)
    begin
        prev_addr <= raddr;
        if (we === 1'b1)
            mem[prev_addr] <= wdata;
    end
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = !core_clk_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Flags are start, stop, read and not-acknowledge; ea is the acknowledge expected.
    task automatic xfer(input logic [3:0] f, input logic [7:0] d, input logic ea);
        int i;
        int j;
        {cmd_start, cmd_stop, cmd_read, cmd_nack} = f;
        cmd_data = d;
        cmd_valid = 1'b1;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge core_clk_i);
            if (cmd_ready === 1'b1)
                break;
        end
        @(negedge core_clk_i);
        cmd_valid = 1'b0;
        for (j = 0; j < 2000 && i < 2000; j++)
        begin
            @(posedge core_clk_i);
            if (rsp_valid === 1'b1)
                break;
        end
        if (i >= 2000 || j >= 2000)
        begin
            err_count++;
            close_out();
        end
        @(negedge core_clk_i);
        chk({15'h0000, rsp_ack}, {15'h0000, ea});
    endtask
    task automatic set_ptr(input logic [9:0] p, input logic stop);
        xfer(4'h8, {TSRP_ADDR_FIXED, strap_h, strap_l, 1'b0}, 1'b1);
        xfer(4'h0, {6'h3F, p[9:8]}, 1'b1);
        xfer({1'b0, stop, 2'h0}, p[7:0], 1'b1);
    endtask
    task automatic wr_words(input logic [9:0] p, input int n, input logic [15:0] v, input logic odd);
        logic [15:0] w;
        set_ptr(p, 1'b0);
        for (int k = 0; k < n; k++)
        begin
            w = v + 16'(k);
            xfer(4'h0, w[15:8], 1'b1);
            xfer({1'b0, k == n - 1 && !odd, 2'h0}, w[7:0], 1'b1);
            if (int'(p) + k < 1023)
                shadow[int'(p) + k] = w;
        end
        if (odd)
            xfer(4'h4, 8'hEE, 1'b1);
    endtask
    task automatic rd_words(input logic [9:0] p, input int n);
        int q;
        logic last;
        xfer(4'h8, {TSRP_ADDR_FIXED, strap_h, strap_l, 1'b1}, 1'b1);
        for (int k = 0; k < 2 * n; k++)
        begin
            q = int'(p) + k / 2;
            q = q > 1023 ? 1023 : q;
            last = k == 2 * n - 1;
            xfer({1'b0, last, 1'b1, last}, 8'h00, !last);
            chk({8'h00, rsp_data}, {8'h00, k[0] ? shadow[q][7:0] : shadow[q][15:8]});
        end
    endtask
    initial
    begin
        {rst_i, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack, strap_h, strap_l} = 8'h80;
        cmd_data = 8'h00;
        err_count = 0;
        n_checks = 0;
        for (int a = 0; a < 1024; a++)
        begin
            mem[a] = 16'hA000 | 16'(a);
            shadow[a] = 16'hA000 | 16'(a);
        end
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            {strap_h, strap_l} = 2'(s);
            xfer(4'hC, {TSRP_ADDR_FIXED, 2'(s), 1'b0}, 1'b1);
            xfer(4'h8, {TSRP_ADDR_FIXED, 2'(s) ^ 2'h1, 1'b1}, 1'b0);
            xfer(4'h4, 8'h00, 1'b0);
            xfer(4'hC, {TSRP_ADDR_FIXED ^ 5'h10, 2'(s), 1'b0}, 1'b0);
        end
        wr_words(10'h155, 3, 16'h1234, 1'b1);
        for (int i = 0; i < 100 && raddr !== 10'h000; i++)
            @(negedge core_clk_i);
        chk({6'h00, raddr}, 16'h0000);
        set_ptr(10'h155, 1'b0);
        rd_words(10'h155, 3);
        rd_words(10'h000, 2);
        wr_words(10'h3FE, 3, 16'h5A00, 1'b0);
        set_ptr(10'h3FE, 1'b0);
        rd_words(10'h3FE, 3);
        for (int a = 0; a < 1024; a++)
            chk(mem[a], shadow[a]);
        close_out();
    end
endmodule
`default_nettype wire
